// >>> emc_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// - tx options: duplex, auto fcs, padding
// - promiscuous accepts every frame except bad fcs frames when reject is set
// - multicast accepts group plus own frames
// - bad fcs frames rejected when set
// - timestamp routes tx/rx status to timer
// - configuration reads back programmed values
// - disable stops tx, rx, flushes fifo
// - enable starts tx, rx, empties fifo
// - clear mask deasserts selected latched sources, not rx waiting
// - per-source enables gate interrupt line
// - line chip interrupt raises source
// - management completion raises source
// - rx length, fcs, phy error source
// - rx overflow raises source
// - tx done raises source
// - tx retry or length fault source
// - rx waiting while frames queued
// - raw and masked status readable
// - packet count up on fcs, down read
module emc_ctrl
    import emc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cfg_we,
    input wire logic [CFG_W-1:0] cfg_wdata,
    output logic [CFG_W-1:0] cfg_rdata,
    output logic full_duplex_tx_en,
    output logic auto_fcs_append_en,
    output logic short_frame_pad_en,
    output logic accept_all_frames_en,
    output logic accept_group_frames_en,
    output logic reject_bad_fcs_frames,
    output logic timestamp_capture_route_en,
    input wire logic enable_req,
    input wire logic disable_req,
    output logic tx_on,
    output logic rx_on,
    output logic rx_fifo_flush,
    input wire logic rx_dest_own,
    input wire logic rx_dest_group,
    input wire logic rx_frame_end,
    input wire logic rx_fcs_ok,
    input wire logic rx_len_bad,
    input wire logic rx_phy_err,
    input wire logic rx_too_big,
    output logic rx_frame_keep,
    input wire logic rx_frame_read_done,
    output logic [PKT_CNT_W-1:0] rx_pkt_count,
    input wire logic line_chip_irq,
    input wire logic mgmt_done,
    input wire logic tx_sent_ok,
    input wire logic tx_retry_fail,
    input wire logic tx_len_bad,
    input wire logic [NUM_INT-1:0] int_en_set,
    input wire logic [NUM_INT-1:0] int_en_clr,
    input wire logic [NUM_INT-1:0] int_clear,
    output logic [NUM_INT-1:0] int_en,
    output logic [NUM_INT-1:0] int_raw,
    output logic [NUM_INT-1:0] int_masked,
    output logic irq,
    output logic [1:0] timer_capture_input
);
    logic [CFG_W-1:0] cfg;
    emc_state_t state;
    logic [NUM_INT-1:0] ev_set;
    logic [NUM_INT-1:0] lat;
    logic [NUM_INT-1:0] next_raw;
    logic [NUM_INT-1:0] next_en;
    logic keep;
    logic pkt_up;
    logic pkt_dn;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cfg <= CFG_RESET;
        else if (cfg_we)
            cfg <= cfg_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cfg_rdata <= CFG_RESET;
        else
            cfg_rdata <= cfg_we ? cfg_wdata : cfg;
    end

    // drive option outputs from the next value so they follow cfg
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            short_frame_pad_en <= 1'b0;
            auto_fcs_append_en <= 1'b0;
            full_duplex_tx_en <= 1'b0;
            accept_group_frames_en <= 1'b0;
            accept_all_frames_en <= 1'b0;
            reject_bad_fcs_frames <= 1'b0;
            timestamp_capture_route_en <= 1'b0;
        end
        else if (cfg_we)
        begin
            short_frame_pad_en <= cfg_wdata[CFG_PAD];
            auto_fcs_append_en <= cfg_wdata[CFG_FCS];
            full_duplex_tx_en <= cfg_wdata[CFG_DPLX];
            accept_group_frames_en <= cfg_wdata[CFG_GROUP];
            accept_all_frames_en <= cfg_wdata[CFG_ALL];
            reject_bad_fcs_frames <= cfg_wdata[CFG_BADFCS];
            timestamp_capture_route_en <= cfg_wdata[CFG_TS];
        end
    end

    // enable/disable sequencing; flush lasts one cycle on each transition
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state <= EMC_OFF;
        else
        begin
            unique case (state)
                EMC_OFF:
                    if (enable_req)
                        state <= EMC_FLUSH;
                EMC_FLUSH:
                    state <= EMC_ON;
                EMC_ON:
                    if (disable_req)
                        state <= EMC_OFF;
                default:
                    state <= EMC_OFF;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tx_on <= 1'b0;
            rx_on <= 1'b0;
            rx_fifo_flush <= 1'b0;
        end
        else
        begin
            tx_on <= (state == EMC_FLUSH) || (state == EMC_ON && !disable_req);
            rx_on <= (state == EMC_FLUSH) || (state == EMC_ON && !disable_req);
            rx_fifo_flush <= (state == EMC_OFF && enable_req)
                || (state == EMC_ON && disable_req);
        end
    end

    always_comb
    begin
        keep = accept_all_frames_en || rx_dest_own
            || (accept_group_frames_en && rx_dest_group);
        if (reject_bad_fcs_frames && !rx_fcs_ok)
            keep = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rx_frame_keep <= 1'b0;
        else
            rx_frame_keep <= rx_on && rx_frame_end && keep;
    end

    // packet counter; saturates so a runaway source cannot wrap
    assign pkt_up = rx_on && rx_frame_end && rx_fcs_ok && keep && !rx_too_big;
    assign pkt_dn = rx_frame_read_done && rx_pkt_count != '0;
    always_ff @(posedge clk)
    begin
        if (!rst_n || rx_fifo_flush)
            rx_pkt_count <= '0;
        else if (pkt_up && !pkt_dn && rx_pkt_count != PKT_CNT_MAX)
            rx_pkt_count <= rx_pkt_count + 1'b1;
        else if (pkt_dn && !pkt_up)
            rx_pkt_count <= rx_pkt_count - 1'b1;
    end

    // interrupt event sources
    always_comb
    begin
        ev_set = '0;
        ev_set[INT_LINE] = line_chip_irq;
        ev_set[INT_MGMT] = mgmt_done;
        ev_set[INT_RX_FAULT] = rx_frame_end && (rx_len_bad || !rx_fcs_ok || rx_phy_err);
        ev_set[INT_RX_OVF] = rx_frame_end && rx_too_big;
        ev_set[INT_TX_DONE] = tx_sent_ok;
        ev_set[INT_TX_FAULT] = tx_retry_fail || tx_len_bad;
    end

    genvar g;
    generate
        for (g = 1; g < NUM_INT; g++)
        begin : g_src
            emc_int_src u_src (
                .clk(clk),
                .rst_n(rst_n),
                .set(ev_set[g]),
                .clr(int_clear[g]),
                .flag(lat[g])
            );
        end
    endgenerate
    assign lat[INT_RX_WAIT] = 1'b0;

    always_comb
    begin
        next_raw = lat;
        next_raw[INT_RX_WAIT] = (rx_pkt_count != '0);
    end

    assign next_en = (int_en | int_en_set) & ~int_en_clr;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            int_en <= INT_EN_RESET;
        else
            int_en <= next_en;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            int_raw <= INT_RESET;
            int_masked <= INT_RESET;
            irq <= 1'b0;
        end
        else
        begin
            int_raw <= next_raw;
            // new enables, so the masked view never lags int_en by a cycle
            int_masked <= next_raw & next_en;
            irq <= |(next_raw & next_en);
        end
    end

    // timer capture route: bit0 tx done, bit1 rx waiting
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            timer_capture_input <= 2'h0;
        else if (timestamp_capture_route_en)
            timer_capture_input <= {next_raw[INT_RX_WAIT], next_raw[INT_TX_DONE]};
        else
            timer_capture_input <= 2'h0;
    end

    chk_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
        irq |-> (|(int_raw & int_en))) else $error("irq without enabled source");
    chk_masked_view: assert property (@(posedge clk) disable iff (!rst_n)
        int_masked == (int_raw & int_en)) else $error("masked status wrong");
    chk_disable_flush: assert property (@(posedge clk) disable iff (!rst_n)
        (state == EMC_ON && disable_req) |=> rx_fifo_flush && !tx_on && !rx_on)
        else $error("disable not honoured");
    chk_enable_on: assert property (@(posedge clk) disable iff (!rst_n)
        (state == EMC_OFF && enable_req) |=> rx_fifo_flush ##1 (tx_on && rx_on))
        else $error("enable not honoured");
    chk_rx_wait: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 int_raw[INT_RX_WAIT] == ($past(rx_pkt_count) != '0))
        else $error("rx waiting wrong");
    chk_clear_works: assert property (@(posedge clk) disable iff (!rst_n)
        (int_clear[INT_TX_DONE] && !ev_set[INT_TX_DONE]) |=> ##1 !int_raw[INT_TX_DONE])
        else $error("clear ignored");
    chk_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (int_raw[INT_MGMT] && !int_clear[INT_MGMT] && !$past(int_clear[INT_MGMT]))
            |=> int_raw[INT_MGMT])
        else $error("source dropped");
    chk_bad_fcs_drop: assert property (@(posedge clk) disable iff (!rst_n)
        (reject_bad_fcs_frames && rx_frame_end && !rx_fcs_ok) |=> !rx_frame_keep)
        else $error("bad fcs delivered");
    chk_ts_route: assert property (@(posedge clk) disable iff (!rst_n)
        !timestamp_capture_route_en |=> timer_capture_input == 2'h0)
        else $error("route leak");
    chk_cfg_read: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_we |=> cfg_rdata == $past(cfg_wdata)) else $error("readback wrong");

    cov_irq: cover property (@(posedge clk) irq);
    cov_enable: cover property (@(posedge clk) state == EMC_FLUSH);
    cov_pkt: cover property (@(posedge clk) rx_pkt_count == 8'h02);
    cov_clear: cover property (@(posedge clk) int_clear[INT_TX_DONE] && int_raw[INT_TX_DONE]);
endmodule : emc_ctrl

// >>> emc_ctrl_tb_top.sv
`timescale 1ns/100ps
module emc_ctrl_tb_top;
    import emc_pkg::*;
    logic clk, rst_n, cfg_we, enable_req, disable_req, rd, irq, tx_on, rx_on, fl, keep, fe, kept, x;
    logic [CFG_W-1:0] cfg_wdata, cfg_rdata, opt, cfg;
    logic [NUM_INT-1:0] es, ec, icl, int_en, int_raw, int_masked, en, r;
    logic [PKT_CNT_W-1:0] rx_pkt_count, cnt;
    logic [5:0] q, f;
    logic [4:0] ev;
    logic [1:0] tci;
    logic [5:0] ftab [4] = '{6'h01, 6'h0d, 6'h15, 6'h25};
    int itab [9] = '{1, 2, 5, 6, 1, 4, 4, 4, 3};
    int n_errors, checked, seed, cyc;
    emc_line_model line (.clk(clk), .q(q), .fe(fe), .ev(ev));
    emc_ctrl dut (.clk(clk), .rst_n(rst_n), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .full_duplex_tx_en(opt[CFG_DPLX]),
        .auto_fcs_append_en(opt[CFG_FCS]), .short_frame_pad_en(opt[CFG_PAD]),
        .accept_all_frames_en(opt[CFG_ALL]), .accept_group_frames_en(opt[CFG_GROUP]),
        .reject_bad_fcs_frames(opt[CFG_BADFCS]), .timestamp_capture_route_en(opt[CFG_TS]),
        .enable_req(enable_req), .disable_req(disable_req), .tx_on(tx_on), .rx_on(rx_on),
        .rx_fifo_flush(fl), .rx_dest_own(q[0]), .rx_dest_group(q[1]), .rx_frame_end(fe),
        .rx_fcs_ok(q[2]), .rx_len_bad(q[3]), .rx_phy_err(q[4]), .rx_too_big(q[5]),
        .rx_frame_keep(keep), .rx_frame_read_done(rd), .rx_pkt_count(rx_pkt_count),
        .line_chip_irq(ev[3]), .mgmt_done(ev[2]), .tx_sent_ok(ev[1]), .tx_retry_fail(ev[0]),
        .tx_len_bad(ev[4]), .int_en_set(es), .int_en_clr(ec), .int_clear(icl), .int_en(int_en),
        .int_raw(int_raw), .int_masked(int_masked), .irq(irq), .timer_capture_input(tci));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic wcfg(input logic [CFG_W-1:0] w);
        cfg_wdata = w;
        cfg_we = 1'b1;
        cfg = w;
        step(1);
        cfg_we = 1'b0;
    endtask : wcfg
    function automatic logic keep_exp(input logic [CFG_W-1:0] c, input logic [5:0] v);
        return (c[CFG_ALL] | v[0] | (v[1] & c[CFG_GROUP])) & (v[2] | ~c[CFG_BADFCS]);
    endfunction : keep_exp
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard: the whole run needs well under 3000 cycles
    always @(posedge clk)
    begin
        cyc++;
        kept <= kept | keep;
        if (cyc == 6000)
        begin
            n_errors++;
            end_of_test();
        end
    end
    initial
    begin
        {rst_n, cfg_we, cfg_wdata, enable_req, disable_req, rd, es, ec, icl} = '0;
        {cnt, cfg, kept, en} = '0;
        seed = 56;
        step(5);
        rst_n = 1'b1;
        check({cfg_rdata, opt, int_raw, int_en, irq, tx_on, rx_on, rx_pkt_count, tci}, 0);
        for (int i = 0; i < 16; i++)
        begin
            wcfg(i < CFG_W ? 7'h01 << i : 7'($random(seed)));
            check({opt, cfg_rdata}, {cfg, cfg});
            step(1);
        end
        enable_req = 1'b1;
        step(1);
        enable_req = 1'b0;
        check({fl, tx_on, rx_on}, 3'b100);
        step(1);
        check({fl, tx_on, rx_on, rx_pkt_count}, 11'h300);
        for (int i = 0; i < 24; i++)
        begin
            if (i % 6 == 0)
                wcfg(7'($random(seed)));
            f = 6'($random(seed)) & 6'h07;
            kept = 1'b0;
            line.frame(i % 3, f);
            step(4);
            x = keep_exp(cfg, f);
            cnt = cnt + 8'(x & f[2]);
            check(kept, x);
            check(rx_pkt_count, cnt);
            check({int_raw[INT_RX_WAIT], tci[1]}, {cnt != 0, cnt != 0 && cfg[CFG_TS]});
        end
        while (cnt != 0)
        begin
            rd = 1'b1;
            step(1);
            rd = 1'b0;
            cnt--;
            step(3);
            check({rx_pkt_count, int_raw[INT_RX_WAIT]}, {cnt, cnt != 0});
        end
        // drop faults latched by the random frames so only one source stands
        icl = 7'h7e;
        step(1);
        icl = 7'h00;
        wcfg(7'h40);
        for (int k = 0; k < 9; k++)
        begin
            if (k < 5)
                line.fire(k);
            else
                line.frame(k % 2, ftab[k - 5]);
            step(4);
            r = 7'h01 << itab[k];
            check(int_raw[itab[k]], 1'b1);
            if (k == 1)
                check(tci[0], 1'b1);
            es = 7'($random(seed));
            ec = 7'($random(seed)) | 7'h01;
            en = (en | es) & ~ec;
            step(1);
            {es, ec} = '0;
            step(3);
            check({int_en, int_masked[6:1], irq}, {en, 6'((r & en) >> 1), |(r & en)});
            check(int_raw[itab[k]], 1'b1);
            // clearing early, before the handler returns
            icl = 7'h7e;
            step(1);
            icl = 7'h00;
            step(3);
            check({int_raw[6:1], irq}, 0);
        end
        line.frame(0, 6'h05);
        step(4);
        disable_req = 1'b1;
        step(1);
        disable_req = 1'b0;
        check({fl, tx_on, rx_on}, 3'b100);
        step(3);
        check({rx_pkt_count, int_raw[INT_RX_WAIT]}, 0);
        end_of_test();
    end
endmodule : emc_ctrl_tb_top

// >>> emc_int_src.sv
`timescale 1ns/100ps
// one latched interrupt source: set wins over clear
module emc_int_src
    import emc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic set,
    input wire logic clr,
    output logic flag
);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            flag <= 1'b0;
        else if (set)
            flag <= 1'b1;
        else if (clr)
            flag <= 1'b0;
    end

    chk_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        set |=> flag) else $error("set lost");
endmodule : emc_int_src

// >>> emc_line_model.sv
`timescale 1ns/100ps
// line side: frame ends with qualifiers, chip and transmit events
module emc_line_model (
    input wire logic clk,
    output logic [5:0] q,
    output logic fe,
    output logic [4:0] ev
);
    initial
    begin
        q = 6'h00;
        fe = 1'b0;
        ev = 5'h00;
    end
    // q: own, group, fcs ok, len bad, phy err, too big; gap makes slow answers
    task automatic frame(input int gap, input logic [5:0] f);
        repeat (gap) @(negedge clk);
        q = f;
        fe = 1'b1;
        @(negedge clk);
        fe = 1'b0;
        // stale qualifiers must not look valid, so show the inverse
        q = ~f;
    endtask : frame
    task automatic fire(input int k);
        ev[k] = 1'b1;
        @(negedge clk);
        ev[k] = 1'b0;
    endtask : fire
endmodule : emc_line_model

// >>> emc_pkg.sv
package emc_pkg;
    // interrupt source bit positions
    localparam int INT_RX_WAIT = 0;
    localparam int INT_TX_FAULT = 1;
    localparam int INT_TX_DONE = 2;
    localparam int INT_RX_OVF = 3;
    localparam int INT_RX_FAULT = 4;
    localparam int INT_MGMT = 5;
    localparam int INT_LINE = 6;
    localparam int NUM_INT = 7;
    localparam logic [6:0] INT_RESET = 7'h00;
    localparam logic [6:0] INT_EN_RESET = 7'h00;
    // configuration word field positions
    localparam int CFG_PAD = 0;
    localparam int CFG_FCS = 1;
    localparam int CFG_DPLX = 2;
    localparam int CFG_GROUP = 3;
    localparam int CFG_ALL = 4;
    localparam int CFG_BADFCS = 5;
    localparam int CFG_TS = 6;
    localparam int CFG_W = 7;
    localparam logic [6:0] CFG_RESET = 7'h00;
    localparam int PKT_CNT_W = 8;
    localparam logic [7:0] PKT_CNT_MAX = 8'hff;
    typedef enum logic [1:0] {EMC_OFF, EMC_FLUSH, EMC_ON} emc_state_t;
endpackage : emc_pkg
